// ---- pta_regs.svh ----
// pta_regs.svh: register offsets, field positions, reset values and codes
// assumes: included by the datapath; holds definitions only
`ifndef PTA_REGS_SVH
`define PTA_REGS_SVH
`define PTA_ADR_CTRL   8'h00
`define PTA_ADR_OPA0   8'h04
`define PTA_ADR_OPA1   8'h08
`define PTA_ADR_OPB0   8'h0C
`define PTA_ADR_OPB1   8'h10
`define PTA_ADR_RES0   8'h14
`define PTA_ADR_RES1   8'h18
`define PTA_ADR_STAT   8'h1C
`define PTA_ADR_ERRC   8'h20
`define PTA_CTRL_TYPE  2:0
`define PTA_CTRL_OP    7:4
`define PTA_CTRL_ORDER 8
`define PTA_CTRL_START 31
`define PTA_CTRL_RST   9'h000
`define PTA_ST_CB      0
`define PTA_ST_ERR     1
`define PTA_TYPE_MAX   3'h4
`define PTA_ERR_NONE   16'h0000
`define PTA_ERR_FSRC   16'h0001
`define PTA_ERR_OPTYPE 16'h0002
`define PTA_ERR_TYPE   16'h0003
`define PTA_F_EXP      30:23
`define PTA_F_EXP_MAX  8'hFF
`define PTA_F_BIAS     10'h07F
`endif

// ---- pta_pkg.sv ----
// pta_pkg.sv: operand types, operations and sequencer states
// assumes: nothing beyond a SystemVerilog compiler
`default_nettype none
package pta_pkg;
   typedef enum logic [2:0] {
      PTA_W = 3'h0, PTA_I = 3'h1, PTA_D = 3'h2, PTA_L = 3'h3, PTA_F = 3'h4
   } pta_type_t;
   typedef enum logic [3:0] {
      PTA_MOV = 4'h0, PTA_ADD = 4'h1, PTA_SUB = 4'h2, PTA_AND = 4'h3,
      PTA_OR  = 4'h4, PTA_XOR = 4'h5, PTA_SHL = 4'h6, PTA_MUL = 4'h7,
      PTA_INC = 4'h8
   } pta_op_t;
   typedef enum logic [1:0] {
      PTA_IDLE = 2'h0, PTA_EXEC = 2'h1, PTA_FIN = 2'h3
   } pta_state_t;
endpackage : pta_pkg
`default_nettype wire

// ---- pta_datapath.sv ----
// pta_datapath.sv: typed arithmetic datapath behind a classic Wishbone slave
// assumes: one 25 MHz clock shared with the bus master, active-low async reset
//
// The register offsets and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pta_regs.svh"

module pta_datapath
   import pta_pkg::*;
(
   input  wire logic        i_core_clk,
   input  wire logic        i_resetn,
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [7:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic      [31:0] o_wb_dat,
   output logic             o_wb_ack,
   output logic             o_done,
   output logic             o_carry_borrow_flag,
   output logic             o_exec_error_flag,
   output logic             o_fault_lamp
);

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   // byte-lane merge of a 16-bit register
   function automatic logic [15:0] pta_wr16(input logic [15:0] old,
                                            input logic [15:0] dat,
                                            input logic [1:0]  sel);
      pta_wr16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
   endfunction : pta_wr16

   // add or subtract on the top bits; bit 32 is carry/borrow, or signed overflow when sgn is set
   function automatic logic [32:0] pta_arith(input logic [31:0] a,
                                             input logic [31:0] b,
                                             input logic        sub,
                                             input logic        sgn);
      logic [32:0] s;
      logic        ovf;
      s   = sub ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
      ovf = sub ? ((a[31] != b[31]) && (s[31] != a[31]))
                : ((a[31] == b[31]) && (s[31] != a[31]));
      if (sgn) begin
         pta_arith = {ovf, s[31] ^ ovf, s[30:0]};
      end else begin
         pta_arith = s;
      end
   endfunction : pta_arith

   // float multiply, truncating; bit 32 is over/underflow
   function automatic logic [32:0] pta_fmul(input logic [31:0] a,
                                            input logic [31:0] b);
      logic [47:0] p;
      logic [9:0]  e;
      logic        s;
      s = a[31] ^ b[31];
      p = {1'b1, a[22:0]} * {1'b1, b[22:0]};
      e = {2'h0, a[`PTA_F_EXP]} + {2'h0, b[`PTA_F_EXP]} - `PTA_F_BIAS + {9'h000, p[47]};
      if ((a[`PTA_F_EXP] == 8'h00) || (b[`PTA_F_EXP] == 8'h00)) begin
         pta_fmul = {1'b0, s, 31'h00000000};
      end else if (e[9] || (e == 10'h000)) begin
         pta_fmul = {1'b1, s, 31'h00000000};
      end else if (e >= {2'h0, `PTA_F_EXP_MAX}) begin
         pta_fmul = {1'b1, s, `PTA_F_EXP_MAX, 23'h000000};
      end else begin
         pta_fmul = {1'b0, s, e[7:0], p[47] ? p[46:24] : p[45:23]};
      end
   endfunction : pta_fmul

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [8:0]  ctrl_reg, ctrl_next;
   logic [15:0] opa0_reg, opa0_next;
   logic [15:0] opa1_reg, opa1_next;
   logic [15:0] opb0_reg, opb0_next;
   logic [15:0] opb1_reg, opb1_next;
   logic        ack_reg, ack_next;
   logic [31:0] rdat_reg, rdat_next;
   pta_state_t  state_reg, state_next;
   logic [15:0] res0_reg, res0_next;
   logic [15:0] res1_reg, res1_next;
   logic        cb_reg, cb_next;
   logic        err_reg, err_next;
   logic        cy_reg, cy_next;
   logic        bw_reg, bw_next;
   logic [15:0] errc_reg, errc_next;
   logic        take;
   logic        wr;
   logic        start_req;
   logic        stat_clr;
   pta_type_t   typ;
   pta_op_t     op;
   logic        order;
   logic        narrow;
   logic        sgn;
   logic [31:0] a_val, b_val;
   logic [31:0] a_w, b_w;
   logic [32:0] ar, fm;
   logic [31:0] r;
   logic        cyn, bwn, fln;
   logic [15:0] code;

   // ----------------------------------------------------------------
   // wishbone slave
   // ----------------------------------------------------------------
   // request taken once, answered on the next cycle
   assign take      = i_wb_cyc && i_wb_stb && !ack_reg;
   assign wr        = take && i_wb_we;
   assign start_req = wr && (i_wb_adr == `PTA_ADR_CTRL) && i_wb_sel[3]
                      && i_wb_dat[`PTA_CTRL_START];
   assign stat_clr  = wr && (i_wb_adr == `PTA_ADR_STAT) && i_wb_sel[0]
                      && i_wb_dat[`PTA_ST_ERR];

   // register writes and read mux
   always_comb begin
      ctrl_next = ctrl_reg;
      opa0_next = opa0_reg;
      opa1_next = opa1_reg;
      opb0_next = opb0_reg;
      opb1_next = opb1_reg;
      ack_next  = take;
      rdat_next = rdat_reg;
      if (wr) begin
         rdat_next = 32'h00000000;
         case (i_wb_adr)
            `PTA_ADR_CTRL: begin
               if (i_wb_sel[0]) begin
                  ctrl_next[7:0] = i_wb_dat[7:0];
               end
               if (i_wb_sel[1]) begin
                  ctrl_next[`PTA_CTRL_ORDER] = i_wb_dat[`PTA_CTRL_ORDER];
               end
            end
            `PTA_ADR_OPA0: opa0_next = pta_wr16(opa0_reg, i_wb_dat[15:0], i_wb_sel[1:0]);
            `PTA_ADR_OPA1: opa1_next = pta_wr16(opa1_reg, i_wb_dat[15:0], i_wb_sel[1:0]);
            `PTA_ADR_OPB0: opb0_next = pta_wr16(opb0_reg, i_wb_dat[15:0], i_wb_sel[1:0]);
            `PTA_ADR_OPB1: opb1_next = pta_wr16(opb1_reg, i_wb_dat[15:0], i_wb_sel[1:0]);
            default: ;
         endcase
      end else if (take) begin
         case (i_wb_adr)
            `PTA_ADR_CTRL: rdat_next = {23'h000000, ctrl_reg};
            `PTA_ADR_OPA0: rdat_next = {16'h0000, opa0_reg};
            `PTA_ADR_OPA1: rdat_next = {16'h0000, opa1_reg};
            `PTA_ADR_OPB0: rdat_next = {16'h0000, opb0_reg};
            `PTA_ADR_OPB1: rdat_next = {16'h0000, opb1_reg};
            `PTA_ADR_RES0: rdat_next = {16'h0000, res0_reg};
            `PTA_ADR_RES1: rdat_next = {16'h0000, res1_reg};
            `PTA_ADR_STAT: rdat_next = {27'h0000000, state_reg != PTA_IDLE,
                                        bw_reg, cy_reg, err_reg, cb_reg};
            `PTA_ADR_ERRC: rdat_next = {16'h0000, errc_reg};
            default:       rdat_next = 32'h00000000;
         endcase
      end
   end

   // bus-side registers
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ctrl_reg <= `PTA_CTRL_RST;
         opa0_reg <= 16'h0000;
         opa1_reg <= 16'h0000;
         opb0_reg <= 16'h0000;
         opb1_reg <= 16'h0000;
         ack_reg  <= 1'b0;
         rdat_reg <= 32'h00000000;
      end else begin
         ctrl_reg <= ctrl_next;
         opa0_reg <= opa0_next;
         opa1_reg <= opa1_next;
         opb0_reg <= opb0_next;
         opb1_reg <= opb1_next;
         ack_reg  <= ack_next;
         rdat_reg <= rdat_next;
      end
   end

   assign o_wb_ack = ack_reg;
   assign o_wb_dat = rdat_reg;

   // ----------------------------------------------------------------
   // operand shaping
   // ----------------------------------------------------------------
   // type and half order; 16-bit values ride in the top half
   assign typ    = pta_type_t'(ctrl_reg[`PTA_CTRL_TYPE]);
   assign op     = pta_op_t'(ctrl_reg[`PTA_CTRL_OP]);
   assign order  = ctrl_reg[`PTA_CTRL_ORDER];
   assign a_val  = order ? {opa0_reg, opa1_reg} : {opa1_reg, opa0_reg};
   assign b_val  = order ? {opb0_reg, opb1_reg} : {opb1_reg, opb0_reg};
   assign narrow = (typ == PTA_W) || (typ == PTA_I) || (op == PTA_INC);
   assign sgn    = ((typ == PTA_I) || (typ == PTA_L)) && (op != PTA_INC);
   assign a_w    = narrow ? {opa0_reg, 16'h0000} : a_val;
   assign b_w    = (op == PTA_INC) ? {16'h0001, 16'h0000}
                 : (narrow ? {opb0_reg, 16'h0000} : b_val);
   assign ar     = pta_arith(a_w, b_w, op == PTA_SUB, sgn);
   assign fm     = pta_fmul(a_val, b_val);

   // ----------------------------------------------------------------
   // execution
   // ----------------------------------------------------------------
   // result, indications and error code of the current operation
   always_comb begin
      r    = a_w;
      cyn  = 1'b0;
      bwn  = 1'b0;
      fln  = 1'b0;
      code = `PTA_ERR_NONE;
      case (op)
         PTA_MOV: r = a_w;
         PTA_ADD, PTA_INC: begin
            r   = ar[31:0];
            cyn = ar[32];
         end
         PTA_SUB: begin
            r   = ar[31:0];
            bwn = ar[32];
         end
         PTA_AND: r = a_w & b_w;
         PTA_OR:  r = a_w | b_w;
         PTA_XOR: r = a_w ^ b_w;
         PTA_SHL: begin
            r   = {a_w[30:0], 1'b0};
            cyn = a_w[31];
         end
         default: code = `PTA_ERR_OPTYPE;
      endcase
      if ((typ == PTA_F) && (op != PTA_INC)) begin
         cyn  = 1'b0;
         bwn  = 1'b0;
         code = `PTA_ERR_NONE;
         // exponent all ones: infinity or not-a-number, refused as source
         if ((a_val[`PTA_F_EXP] == `PTA_F_EXP_MAX)
             || ((op == PTA_MUL) && (b_val[`PTA_F_EXP] == `PTA_F_EXP_MAX))) begin
            code = `PTA_ERR_FSRC;
         end else if (op == PTA_MOV) begin
            r = a_val;
         end else if (op == PTA_MUL) begin
            r   = fm[31:0];
            fln = fm[32];
         end else begin
            code = `PTA_ERR_OPTYPE;
         end
      end
      if (ctrl_reg[`PTA_CTRL_TYPE] > `PTA_TYPE_MAX) begin
         code = `PTA_ERR_TYPE;
      end
   end

   // sequencing, storage of results and flags
   always_comb begin
      state_next = state_reg;
      res0_next  = res0_reg;
      res1_next  = res1_reg;
      cb_next    = cb_reg;
      err_next   = err_reg;
      cy_next    = cy_reg;
      bw_next    = bw_reg;
      errc_next  = errc_reg;
      if (stat_clr) begin
         err_next = 1'b0;
      end
      case (state_reg)
         PTA_IDLE: begin
            if (start_req) begin
               state_next = PTA_EXEC;
            end
         end
         PTA_EXEC: begin
            state_next = PTA_FIN;
            if (code != `PTA_ERR_NONE) begin
               err_next  = 1'b1;
               errc_next = code;
            end else begin
               cy_next   = cyn;
               bw_next   = bwn;
               cb_next   = cyn || bwn || fln;
               res0_next = (order || narrow) ? r[31:16] : r[15:0];
               if (!narrow) begin
                  res1_next = order ? r[15:0] : r[31:16];
               end
            end
         end
         PTA_FIN: state_next = PTA_IDLE;
         default: state_next = PTA_IDLE;
      endcase
   end

   // execution registers
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_reg <= PTA_IDLE;
         res0_reg  <= 16'h0000;
         res1_reg  <= 16'h0000;
         cb_reg    <= 1'b0;
         err_reg   <= 1'b0;
         cy_reg    <= 1'b0;
         bw_reg    <= 1'b0;
         errc_reg  <= `PTA_ERR_NONE;
      end else begin
         state_reg <= state_next;
         res0_reg  <= res0_next;
         res1_reg  <= res1_next;
         cb_reg    <= cb_next;
         err_reg   <= err_next;
         cy_reg    <= cy_next;
         bw_reg    <= bw_next;
         errc_reg  <= errc_next;
      end
   end

   assign o_done              = (state_reg == PTA_FIN);
   assign o_carry_borrow_flag = cb_reg;
   assign o_exec_error_flag   = err_reg;
   assign o_fault_lamp        = err_reg;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   logic        exec_go;
   logic [16:0] w_sum17;
   logic [31:0] d_sum;
   logic [31:0] res32;
   assign exec_go = (state_reg == PTA_EXEC);
   assign w_sum17 = {1'b0, opa0_reg} + {1'b0, opb0_reg};
   assign d_sum   = a_val + b_val;
   assign res32   = order ? {res0_reg, res1_reg} : {res1_reg, res0_reg};

   default clocking dp_clk @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);

   property p_done;
      exec_go |=> o_done ##1 !o_done;
   endproperty
   a_done: assert property (p_done) else $error("done not one cycle after exec");

   property p_w_add;
      exec_go && (typ == PTA_W) && (op == PTA_ADD)
      |=> (res0_reg == $past(w_sum17[15:0])) && (cb_reg == $past(w_sum17[16]));
   endproperty
   a_w_add: assert property (p_w_add) else $error("word add wrong");

   property p_i_ovf;
      exec_go && (typ == PTA_I) && (op == PTA_ADD)
      && (opa0_reg == 16'h7FFF) && (opb0_reg == 16'h0001)
      |=> (res0_reg == 16'h0000) && cb_reg && cy_reg;
   endproperty
   a_i_ovf: assert property (p_i_ovf) else $error("signed overflow pattern wrong");

   property p_w_one;
      exec_go && (typ == PTA_W) |=> $stable(res1_reg);
   endproperty
   a_w_one: assert property (p_w_one) else $error("word touched second register");

   property p_d_order;
      exec_go && (typ == PTA_D) && (op == PTA_ADD) |=> res32 == $past(d_sum);
   endproperty
   a_d_order: assert property (p_d_order) else $error("double word halves misplaced");

   property p_fovf;
      exec_go && (typ == PTA_F) && (op == PTA_MUL)
      && (a_val[`PTA_F_EXP] == 8'hFE) && (b_val[`PTA_F_EXP] >= 8'h80)
      && (b_val[`PTA_F_EXP] != 8'hFF)
      |=> cb_reg && (res32[30:0] != 31'h00000000);
   endproperty
   a_fovf: assert property (p_fovf) else $error("float overflow not flagged");

   property p_funder;
      exec_go && (typ == PTA_F) && (op == PTA_MUL)
      && (a_val[`PTA_F_EXP] == 8'h01) && (a_val[22:0] == 23'h000000)
      && (b_val[22:0] == 23'h000000) && (b_val[`PTA_F_EXP] != 8'h00)
      && (b_val[`PTA_F_EXP] <= 8'h7E)
      |=> cb_reg && (res32[30:0] == 31'h00000000);
   endproperty
   a_funder: assert property (p_funder) else $error("float underflow not flagged");

   property p_fzero;
      exec_go && (typ == PTA_F) && (op == PTA_MUL) && (a_val[30:0] == 31'h00000000)
      && (b_val[`PTA_F_EXP] != 8'hFF) |=> !cb_reg;
   endproperty
   a_fzero: assert property (p_fzero) else $error("zero result left flag set");

   property p_finv;
      exec_go && (typ == PTA_F) && (op != PTA_INC) && (a_val[`PTA_F_EXP] == 8'hFF)
      |=> err_reg && o_fault_lamp && (errc_reg == `PTA_ERR_FSRC);
   endproperty
   a_finv: assert property (p_finv) else $error("bad float source not reported");

   property p_cancel;
      exec_go && (code != `PTA_ERR_NONE) |=> $stable(res0_reg) && $stable(res1_reg);
   endproperty
   a_cancel: assert property (p_cancel) else $error("cancelled op changed result");

   property p_sticky;
      err_reg && !stat_clr |=> err_reg;
   endproperty
   a_sticky: assert property (p_sticky) else $error("error flag dropped");

   c_ovf: cover property (exec_go && (typ == PTA_I) && (op == PTA_ADD) ##1 cb_reg);
   c_fmul: cover property (exec_go && (typ == PTA_F) && (op == PTA_MUL) ##1 cb_reg);
   c_err: cover property ($rose(err_reg));
   c_done: cover property (o_done && (typ == PTA_L));

endmodule : pta_datapath
`default_nettype wire

// ---- pta_seq_model.sv ----
// pta_seq_model.sv: behavioural instruction sequencer, classic Wishbone master
// assumes: shares the datapath clock; the bench calls xfer between operations
`timescale 1ns/1ps
`default_nettype none
module pta_seq_model (
   input  wire logic        i_core_clk,
   input  wire logic        i_wb_ack,
   input  wire logic [31:0] i_wb_dat,
   output logic             o_wb_cyc,
   output logic             o_wb_stb,
   output logic             o_wb_we,
   output logic      [7:0]  o_wb_adr,
   output logic      [3:0]  o_wb_sel,
   output logic      [31:0] o_wb_dat
);
   logic hang_reg;
   // ------------------------------------------------------------
   // idle bus at time zero
   // ------------------------------------------------------------
   initial begin
      hang_reg = 1'b0;
      o_wb_cyc = 1'b0;
      o_wb_stb = 1'b0;
      o_wb_we  = 1'b0;
      o_wb_adr = 8'h00;
      o_wb_sel = 4'h0;
      o_wb_dat = 32'h0000_0000;
   end
   // one classic cycle, held until ack is sampled high or 20 clocks pass
   task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                       output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge i_core_clk);
      o_wb_cyc <= 1'b1;
      o_wb_stb <= 1'b1;
      o_wb_we  <= we;
      o_wb_adr <= adr;
      o_wb_sel <= 4'hF;
      o_wb_dat <= wd;
      do begin
         @(posedge i_core_clk);
         n++;
      end while (i_wb_ack !== 1'b1 && n < 20);
      if (i_wb_ack !== 1'b1) begin
         hang_reg = 1'b1;
      end
      rd = i_wb_dat;
      o_wb_cyc <= 1'b0;
      o_wb_stb <= 1'b0;
      o_wb_dat <= ~wd; // released data no longer shows the last value
   endtask : xfer
endmodule : pta_seq_model
`default_nettype wire

// ---- pta_datapath_tb.sv ----
// pta_datapath_tb.sv: self-checking bench for the typed arithmetic datapath
// assumes: pta_pkg, pta_regs.svh and the sequencer model are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "pta_regs.svh"
module pta_datapath_tb;
   import pta_pkg::*;
   logic        core_clk;
   logic        core_resetn;
   logic        cyc, stb, we, ack, done, cb, err, lamp;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat;
   int          fail_count, total_checks, done_cnt;
   logic        cb_at, err_at, lamp_at;
   // ------------------------------------------------------------
   // clock, reset and instances
   // ------------------------------------------------------------
   initial core_clk = 1'b0;
   always #20 core_clk = ~core_clk;
   pta_datapath dut (.i_core_clk(core_clk), .i_resetn(core_resetn), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
      .o_wb_dat(rdat), .o_wb_ack(ack), .o_done(done), .o_carry_borrow_flag(cb),
      .o_exec_error_flag(err), .o_fault_lamp(lamp));
   pta_seq_model seq (.i_core_clk(core_clk), .i_wb_ack(ack), .i_wb_dat(rdat),
      .o_wb_cyc(cyc), .o_wb_stb(stb), .o_wb_we(we), .o_wb_adr(adr), .o_wb_sel(sel),
      .o_wb_dat(wdat));
   // flags captured in the done cycle
   always @(posedge core_clk) begin
      if (done === 1'b1) begin
         done_cnt <= done_cnt + 1;
         cb_at    <= cb;
         err_at   <= err;
         lamp_at  <= lamp;
      end
   end
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      seq.xfer(w, a, d, r);
      if (seq.hang_reg) begin
         fail_count++;
         $display("wrong value at %0t: bus hang", $time);
         wrap_up();
      end
   endtask : bus
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, x);
      chk(x, exp, what);
   endtask : rchk
   // load operands, start, wait for done, judge results and flags
   task automatic run(input logic [2:0] ty, input logic [3:0] op, input logic ord,
      input logic [15:0] a0, a1, b0, b1, r0, r1, input logic [3:0] st, msk);
      logic [31:0] x;
      int n, d0;
      bus(1'b1, `PTA_ADR_OPA0, {16'h0000, a0}, x);
      bus(1'b1, `PTA_ADR_OPA1, {16'h0000, a1}, x);
      bus(1'b1, `PTA_ADR_OPB0, {16'h0000, b0}, x);
      bus(1'b1, `PTA_ADR_OPB1, {16'h0000, b1}, x);
      d0 = done_cnt;
      n = 0;
      bus(1'b1, `PTA_ADR_CTRL, {1'b1, 22'h0, ord, op, 1'b0, ty}, x);
      while (done_cnt == d0 && n < 8) begin
         @(posedge core_clk);
         n++;
      end
      if (done_cnt == d0) begin
         fail_count++;
         $display("wrong value at %0t: no done", $time);
         wrap_up();
      end
      chk({30'h0, err_at, cb_at}, {30'h0, st[1:0]}, "flags at done");
      chk({31'h0, lamp_at}, {31'h0, st[1]}, "fault lamp");
      rchk(`PTA_ADR_RES0, {16'h0000, r0}, "result word 0");
      rchk(`PTA_ADR_RES1, {16'h0000, r1}, "result word 1");
      bus(1'b0, `PTA_ADR_STAT, 32'h0, x);
      chk(x & {28'h0, msk}, {28'h0, st & msk}, "status");
   endtask : run
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      logic [31:0] x;
      rchk(`PTA_ADR_CTRL, 32'h0, "ctrl reset");
      rchk(`PTA_ADR_STAT, 32'h0, "stat reset");
      rchk(`PTA_ADR_ERRC, 32'h0, "errc reset");
      bus(1'b1, 8'h24, 32'h1234_5678, x);
      rchk(8'h24, 32'h0, "unmapped read");
      bus(1'b1, `PTA_ADR_RES0, 32'h0000_5555, x);
      rchk(`PTA_ADR_RES0, 32'h0, "read-only result");
   endtask : t_reset
   task automatic t_word();
      run(PTA_W, PTA_ADD, 1'b0, 16'hFFFE, 0, 16'h0001, 0, 16'hFFFF, 0, 4'h0, 4'hF);
      run(PTA_W, PTA_ADD, 1'b0, 16'hFFFF, 0, 16'h0001, 0, 16'h0000, 0, 4'h5, 4'hF);
      run(PTA_W, PTA_SUB, 1'b0, 16'h0000, 0, 16'h0001, 0, 16'hFFFF, 0, 4'h9, 4'hF);
   endtask : t_word
   task automatic t_logic();
      logic [3:0]  ops [4] = '{PTA_AND, PTA_OR, PTA_XOR, PTA_SHL};
      logic [15:0] res [4] = '{16'h0001, 16'h80FF, 16'h80FE, 16'h0002};
      logic [3:0]  sts [4] = '{4'h0, 4'h0, 4'h0, 4'h5};
      for (int i = 0; i < 4; i++) begin
         run(PTA_W, ops[i], 1'b0, 16'h8001, 0, 16'h00FF, 0, res[i], 0, sts[i], 4'hF);
      end
   endtask : t_logic
   task automatic t_int();
      run(PTA_I, PTA_ADD, 1'b0, 16'h7FFF, 0, 16'h0001, 0, 16'h0000, 0, 4'h5, 4'hF);
      run(PTA_I, PTA_SUB, 1'b0, 16'h8000, 0, 16'h0001, 0, 16'hFFFF, 0, 4'h9, 4'hF);
      run(PTA_I, PTA_ADD, 1'b0, 16'hFFFF, 0, 16'h0001, 0, 16'h0000, 0, 4'h0, 4'hF);
   endtask : t_int
   task automatic t_dword();
      run(PTA_D, PTA_ADD, 1'b1, 16'h0001, 16'hFFFF, 0, 1, 16'h0002, 0, 4'h0, 4'hF);
      run(PTA_D, PTA_ADD, 1'b0, 16'hFFFF, 16'h0001, 1, 0, 0, 16'h0002, 4'h0, 4'hF);
      run(PTA_D, PTA_ADD, 1'b1, 16'hFFFF, 16'hFFFF, 0, 1, 0, 0, 4'h5, 4'hF);
   endtask : t_dword
   task automatic t_long();
      run(PTA_L, PTA_SUB, 1'b1, 16'h8000, 0, 0, 1, 16'hFFFF, 16'hFFFF, 4'h9, 4'hF);
      run(PTA_L, PTA_ADD, 1'b1, 16'h7FFF, 16'hFFFF, 0, 1, 0, 0, 4'h5, 4'hF);
      run(PTA_L, PTA_INC, 1'b1, 16'hFFFF, 16'h1234, 0, 0, 0, 0, 4'h5, 4'hF);
   endtask : t_long
   task automatic t_float();
      run(PTA_F, PTA_MUL, 1'b1, 16'h3F80, 0, 16'h4000, 0, 16'h4000, 0, 4'h0, 4'h3);
      run(PTA_F, PTA_MUL, 1'b1, 16'h7F00, 0, 16'h4000, 0, 16'h7F80, 0, 4'h1, 4'h3);
      run(PTA_F, PTA_MUL, 1'b1, 16'h0080, 0, 16'h3F00, 0, 0, 0, 4'h1, 4'h3);
      run(PTA_F, PTA_MUL, 1'b1, 0, 0, 16'h3F80, 0, 0, 0, 4'h0, 4'h3);
      run(PTA_F, PTA_MOV, 1'b1, 0, 16'h0001, 0, 0, 0, 16'h0001, 4'h0, 4'h3);
   endtask : t_float
   task automatic t_err();
      logic [31:0] x;
      run(PTA_F, PTA_MOV, 1'b1, 16'h7F80, 0, 0, 0, 0, 16'h0001, 4'h2, 4'h3);
      rchk(`PTA_ADR_ERRC, {16'h0000, `PTA_ERR_FSRC}, "errc infinity");
      run(PTA_F, PTA_MOV, 1'b1, 16'h7FC0, 0, 0, 0, 0, 16'h0001, 4'h2, 4'h3);
      bus(1'b1, `PTA_ADR_STAT, 32'h0000_0002, x);
      rchk(`PTA_ADR_STAT, 32'h0, "flag cleared");
      chk({31'h0, lamp}, 32'h0, "lamp cleared");
      run(PTA_W, PTA_MUL, 1'b0, 1, 0, 1, 0, 0, 16'h0001, 4'h2, 4'h3);
      rchk(`PTA_ADR_ERRC, {16'h0000, `PTA_ERR_OPTYPE}, "errc op type");
      run(3'h5, PTA_ADD, 1'b0, 1, 0, 1, 0, 0, 16'h0001, 4'h2, 4'h3);
      rchk(`PTA_ADR_ERRC, {16'h0000, `PTA_ERR_TYPE}, "errc bad type");
   endtask : t_err
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      fail_count   = 0;
      total_checks = 0;
      done_cnt     = 0;
      cb_at        = 1'b0;
      err_at       = 1'b0;
      lamp_at      = 1'b0;
      core_resetn  = 1'b0;
      repeat (4) @(posedge core_clk);
      core_resetn <= 1'b1;
      t_reset();
      t_word();
      t_logic();
      t_int();
      t_dword();
      t_long();
      t_float();
      t_err();
      wrap_up();
   end
endmodule : pta_datapath_tb
`default_nettype wire
